/* common/pcu_pkg.sv */
// Purpose: Shared constants and types of the position capture unit
// Assumes: One 50 MHz clock, synchronous active-high reset
// Notes: Register offsets are byte addresses of 32-bit words
package pcu_pkg;
  // Widths
  localparam int PCU_AW = 8;
  localparam int PCU_DW = 32;
  localparam int PCU_PW = 32;
  localparam int PCU_NDI = 16;
  localparam int PCU_AXW = 8;
  localparam int PCU_SELW = 4;
  localparam int PCU_ACTW = 3;
  localparam int PCU_MODEW = 3;
  localparam int PCU_FLTW = 16;
  // Register offsets
  localparam logic [PCU_AW-1:0] PCU_REG_CTRL = 8'h00;
  localparam logic [PCU_AW-1:0] PCU_REG_CFG = 8'h04;
  localparam logic [PCU_AW-1:0] PCU_REG_STAT = 8'h08;
  localparam logic [PCU_AW-1:0] PCU_REG_FAULT = 8'h0c;
  localparam logic [PCU_AW-1:0] PCU_REG_RISE = 8'h10;
  localparam logic [PCU_AW-1:0] PCU_REG_FALL = 8'h14;
  localparam logic [PCU_AW-1:0] PCU_REG_P1_FALL = 8'h18;
  localparam logic [PCU_AW-1:0] PCU_REG_P1_RISE = 8'h1c;
  localparam logic [PCU_AW-1:0] PCU_REG_P2_FALL = 8'h20;
  localparam logic [PCU_AW-1:0] PCU_REG_P2_RISE = 8'h24;
  // Probe slots, index is {probe two, rising}
  localparam int PCU_PRB_P1F = 0;
  localparam int PCU_PRB_P1R = 1;
  localparam int PCU_PRB_P2F = 2;
  localparam int PCU_PRB_P2R = 3;
  // Control fields
  localparam int PCU_CTRL_CAP_EXE = 0;
  localparam int PCU_CTRL_ABT_EXE = 1;
  localparam int PCU_CTRL_ABT_AXIS = 8;
  // Configuration fields
  localparam int PCU_CFG_MODE = 0;
  localparam int PCU_CFG_POL = 3;
  localparam int PCU_CFG_TRIG = 4;
  localparam int PCU_CFG_ARM = 8;
  localparam int PCU_CFG_AXIS = 16;
  localparam int PCU_CFG_ACT = 24;
  // Status fields
  localparam int PCU_ST_CAP_BUSY = 0;
  localparam int PCU_ST_CAP_DONE = 1;
  localparam int PCU_ST_ARMED = 2;
  localparam int PCU_ST_CAP_ERR = 3;
  localparam int PCU_ST_ABT_BUSY = 4;
  localparam int PCU_ST_ABT_DONE = 5;
  localparam int PCU_ST_ABORTED = 6;
  localparam int PCU_ST_ABT_ERR = 7;
  localparam int PCU_ST_TOUCH = 8;
  // Axis index from which the second probe input is used
  localparam logic [PCU_AXW-1:0] PCU_PROBE_TWO_MIN = 8'h20;
  localparam logic [1:0] PCU_TOUCH_STEP = 2'h1;
  // Fault codes
  localparam logic [PCU_FLTW-1:0] PCU_FLT_NONE = 16'h0000;
  localparam logic [PCU_FLTW-1:0] PCU_FLT_MODE = 16'h0001;
  localparam logic [PCU_FLTW-1:0] PCU_FLT_AXIS = 16'h0002;
  localparam logic [PCU_FLTW-1:0] PCU_FLT_ABT_AXIS = 16'h0003;
  localparam logic [PCU_FLTW-1:0] PCU_FLT_ABT_IDLE = 16'h0004;

  typedef enum logic [PCU_MODEW-1:0] {
    PCU_M_HSC_SINGLE, PCU_M_HSC_CONT, PCU_M_HSC_ARMED, PCU_M_ENC_SINGLE,
    PCU_M_ENC_CONT, PCU_M_PRB_SINGLE, PCU_M_PRB_CONT, PCU_M_BAD
  } pcu_mode_e;
  typedef enum logic [1:0] {PCU_CAP_IDLE, PCU_CAP_WAIT, PCU_CAP_DONE} pcu_cap_e;
  typedef enum logic {PCU_ABT_IDLE, PCU_ABT_RUN} pcu_abt_e;

  typedef struct packed {
    pcu_mode_e mode;
    logic pol;
    logic [PCU_SELW-1:0] trig_sel;
    logic [PCU_SELW-1:0] arm_sel;
    logic [PCU_AXW-1:0] axis;
    logic [PCU_ACTW-1:0] act_axis;
  } pcu_cfg_s;

  typedef struct packed {
    logic valid;
    logic second;
    logic rising;
    logic [PCU_PW-1:0] pos;
  } pcu_probe_s;
endpackage : pcu_pkg

/* logic/pcu_capture.sv */
// Purpose: Position capture unit with capture abort
// Assumes: Position sources sampled on i_ref_clk
// Notes: Start and abort act on rising edges of control bits
// Behaviour
// RULE1: Mode 0 latches counter once, first edge
// RULE2: Mode 1 relatches counter on every edge
// RULE3: Mode 2 capture needs arming edge first
// RULE4: Counter modes use counter channel axis index
// RULE5: Mode 3 latches encoder once, first edge
// RULE6: Mode 4 relatches encoder on every edge
// RULE7: Encoder modes read chosen source encoder
// RULE8: Mode 5 single probe capture, source ignored
// RULE9: Mode 6 continuous probe capture
// RULE10: Capture in hardware, independent of software
// RULE11: Abort continuous capture before changing trigger
// RULE12: Two probes, four edge values recorded
// RULE13: Probe one and two use own inputs
// RULE14: Probe two axis is node plus 31
// RULE15: Abort uses same axis index as capture
// RULE16: Abort starts on execute rising edge
// RULE17: Abort reports busy, done, aborted, error, code
// RULE18: Polarity 0 falling, 1 rising edge
// RULE19: Selectors 0-7 bank one, 8-15 bank two
// RULE20: Modes 2 and 4 count latches 0-3
// RULE21: Pins synchronised; value stored on edge cycle
//
// The implementer's own choices: the address map and the plain strobed port.
module pcu_capture
  import pcu_pkg::*;
#(
  parameter int N_HSC = 5,
  parameter int N_ENC = 5
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Register port
  input wire logic [PCU_AW-1:0] i_reg_addr,
  input wire logic [PCU_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [PCU_DW-1:0] o_reg_rdata,
  // Trigger pins, two banks of eight
  input wire logic [PCU_NDI-1:0] i_dig_in,
  // Position sources
  input wire logic [N_HSC*PCU_PW-1:0] i_hsc_pos,
  input wire logic [N_ENC*PCU_PW-1:0] i_enc_pos,
  input wire pcu_probe_s i_probe,
  // Results and status
  output logic [PCU_PW-1:0] o_rising_latch_value,
  output logic [PCU_PW-1:0] o_falling_latch_value,
  output logic o_capture_busy,
  output logic o_capture_done,
  output logic [1:0] o_latch_count,
  output logic o_abort_busy
);
  if (N_HSC < 1 || N_HSC > 16 || N_ENC < 1 || N_ENC > 8) begin : g_bad_param
    $error("pcu_capture: N_HSC must be 1..16 and N_ENC 1..8");
  end

  typedef struct packed {
    pcu_cfg_s cfg;
    pcu_cfg_s run;
    logic cap_exe;
    logic cap_exe_p;
    logic abt_exe;
    logic abt_exe_p;
    logic [PCU_AXW-1:0] abt_axis;
    pcu_cap_e cap_st;
    pcu_abt_e abt_st;
    logic armed;
    logic cap_err;
    logic abt_done;
    logic abt_aborted;
    logic abt_err;
    logic [1:0] touch;
    logic [PCU_FLTW-1:0] fault;
    logic [PCU_NDI-1:0] pin_p;
    logic [PCU_PW-1:0] rise_val;
    logic [PCU_PW-1:0] fall_val;
    logic [3:0][PCU_PW-1:0] probe_val;
    logic [PCU_DW-1:0] rdata;
  } pcu_state_s;

  function automatic logic sel_edge(input logic [PCU_NDI-1:0] rise, input logic [PCU_NDI-1:0] fall,
                                    input logic [PCU_SELW-1:0] sel, input logic pol);
    sel_edge = pol ? rise[sel] : fall[sel];
  endfunction : sel_edge

  function automatic int unsigned clamp_idx(input logic [PCU_AXW-1:0] v, input int unsigned n);
    clamp_idx = (32'(v) < n) ? 32'(v) : 32'd0;
  endfunction : clamp_idx

  function automatic logic is_prb(input pcu_mode_e m);
    is_prb = (m == PCU_M_PRB_SINGLE) || (m == PCU_M_PRB_CONT);
  endfunction : is_prb

  pcu_state_s q;
  pcu_state_s d;
  logic [PCU_NDI-1:0] pin_lvl;
  logic [PCU_NDI-1:0] pin_rise;
  logic [PCU_NDI-1:0] pin_fall;
  logic cap_start;
  logic abt_start;
  logic trig_hit;
  logic arm_hit;
  logic prb_two;
  logic prb_hit;
  logic hit;
  logic single;
  logic [PCU_PW-1:0] hsc_pos;
  logic [PCU_PW-1:0] enc_pos;
  logic [PCU_PW-1:0] cap_pos;
  logic [PCU_FLTW-1:0] start_fault;
  logic [PCU_DW-1:0] stat_word;
  logic [PCU_DW-1:0] rd_word;

  // Pin synchroniser
  pcu_sync #(.W(PCU_NDI)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_raw(i_dig_in),
    .o_level(pin_lvl)
  ); // [RULE21]

  // Edge detection on filtered pins
  assign pin_rise = pin_lvl & ~q.pin_p;
  assign pin_fall = ~pin_lvl & q.pin_p;
  assign cap_start = q.cap_exe & ~q.cap_exe_p;
  assign abt_start = q.abt_exe & ~q.abt_exe_p; // [RULE16]
  assign trig_hit = sel_edge(pin_rise, pin_fall, q.run.trig_sel, q.run.pol); // [RULE18] [RULE19]
  assign arm_hit = sel_edge(pin_rise, pin_fall, q.run.arm_sel, 1'b1); // [RULE19]

  // Source selection
  assign hsc_pos = i_hsc_pos[clamp_idx(q.run.axis, N_HSC)*PCU_PW +: PCU_PW]; // [RULE4]
  assign enc_pos = i_enc_pos[clamp_idx(PCU_AXW'(q.run.act_axis), N_ENC)*PCU_PW +: PCU_PW]; // [RULE7]
  assign prb_two = q.run.axis >= PCU_PROBE_TWO_MIN; // [RULE14]
  assign prb_hit = i_probe.valid && (i_probe.second == prb_two) && (i_probe.rising == q.run.pol); // [RULE13]

  always_comb begin
    unique case (q.run.mode)
      PCU_M_HSC_SINGLE, PCU_M_HSC_CONT: begin
        cap_pos = hsc_pos;
        hit = trig_hit;
        single = (q.run.mode == PCU_M_HSC_SINGLE); // [RULE1] [RULE2]
      end
      PCU_M_HSC_ARMED: begin
        cap_pos = hsc_pos;
        hit = trig_hit && q.armed; // [RULE3]
        single = 1'b0;
      end
      PCU_M_ENC_SINGLE, PCU_M_ENC_CONT: begin
        cap_pos = enc_pos; // [RULE7]
        hit = trig_hit;
        single = (q.run.mode == PCU_M_ENC_SINGLE); // [RULE5] [RULE6]
      end
      PCU_M_PRB_SINGLE, PCU_M_PRB_CONT: begin
        cap_pos = i_probe.pos; // [RULE8]
        hit = prb_hit;
        single = (q.run.mode == PCU_M_PRB_SINGLE); // [RULE9]
      end
      default: begin
        cap_pos = '0;
        hit = 1'b0;
        single = 1'b1;
      end
    endcase
  end

  // Start check on the configuration being taken
  always_comb begin
    start_fault = PCU_FLT_NONE;
    if (q.cfg.mode == PCU_M_BAD) begin
      start_fault = PCU_FLT_MODE;
    end else if (q.cfg.mode <= PCU_M_HSC_ARMED && 32'(q.cfg.axis) >= N_HSC) begin
      start_fault = PCU_FLT_AXIS;
    end else if ((q.cfg.mode == PCU_M_ENC_SINGLE || q.cfg.mode == PCU_M_ENC_CONT) && 32'(q.cfg.act_axis) >= N_ENC) begin
      start_fault = PCU_FLT_AXIS;
    end
  end

  // Status and read mux
  always_comb begin
    stat_word = '0;
    stat_word[PCU_ST_CAP_BUSY] = (q.cap_st == PCU_CAP_WAIT);
    stat_word[PCU_ST_CAP_DONE] = (q.cap_st == PCU_CAP_DONE);
    stat_word[PCU_ST_ARMED] = q.armed;
    stat_word[PCU_ST_CAP_ERR] = q.cap_err;
    stat_word[PCU_ST_ABT_BUSY] = (q.abt_st == PCU_ABT_RUN);
    stat_word[PCU_ST_ABT_DONE] = q.abt_done;
    stat_word[PCU_ST_ABORTED] = q.abt_aborted;
    stat_word[PCU_ST_ABT_ERR] = q.abt_err;
    stat_word[PCU_ST_TOUCH +: 2] = q.touch;
    rd_word = '0;
    unique case (i_reg_addr)
      PCU_REG_CTRL: begin
        rd_word[PCU_CTRL_CAP_EXE] = q.cap_exe;
        rd_word[PCU_CTRL_ABT_EXE] = q.abt_exe;
        rd_word[PCU_CTRL_ABT_AXIS +: PCU_AXW] = q.abt_axis;
      end
      PCU_REG_CFG: begin
        rd_word[PCU_CFG_MODE +: PCU_MODEW] = q.cfg.mode;
        rd_word[PCU_CFG_POL] = q.cfg.pol;
        rd_word[PCU_CFG_TRIG +: PCU_SELW] = q.cfg.trig_sel;
        rd_word[PCU_CFG_ARM +: PCU_SELW] = q.cfg.arm_sel;
        rd_word[PCU_CFG_AXIS +: PCU_AXW] = q.cfg.axis;
        rd_word[PCU_CFG_ACT +: PCU_ACTW] = q.cfg.act_axis;
      end
      PCU_REG_STAT: rd_word = stat_word;
      PCU_REG_FAULT: rd_word[PCU_FLTW-1:0] = q.fault; // [RULE17]
      PCU_REG_RISE: rd_word = q.rise_val;
      PCU_REG_FALL: rd_word = q.fall_val;
      PCU_REG_P1_FALL: rd_word = q.probe_val[PCU_PRB_P1F];
      PCU_REG_P1_RISE: rd_word = q.probe_val[PCU_PRB_P1R];
      PCU_REG_P2_FALL: rd_word = q.probe_val[PCU_PRB_P2F];
      PCU_REG_P2_RISE: rd_word = q.probe_val[PCU_PRB_P2R];
      default: rd_word = '0;
    endcase
  end

  // Next state
  always_comb begin
    d = q;
    d.pin_p = pin_lvl;
    d.cap_exe_p = q.cap_exe;
    d.abt_exe_p = q.abt_exe;
    d.rdata = i_reg_rd ? rd_word : '0;
    if (i_reg_wr && i_reg_addr == PCU_REG_CTRL) begin
      d.cap_exe = i_reg_wdata[PCU_CTRL_CAP_EXE];
      d.abt_exe = i_reg_wdata[PCU_CTRL_ABT_EXE];
      d.abt_axis = i_reg_wdata[PCU_CTRL_ABT_AXIS +: PCU_AXW];
    end
    if (i_reg_wr && i_reg_addr == PCU_REG_CFG) begin
      d.cfg.mode = pcu_mode_e'(i_reg_wdata[PCU_CFG_MODE +: PCU_MODEW]);
      d.cfg.pol = i_reg_wdata[PCU_CFG_POL];
      d.cfg.trig_sel = i_reg_wdata[PCU_CFG_TRIG +: PCU_SELW];
      d.cfg.arm_sel = i_reg_wdata[PCU_CFG_ARM +: PCU_SELW];
      d.cfg.axis = i_reg_wdata[PCU_CFG_AXIS +: PCU_AXW];
      d.cfg.act_axis = i_reg_wdata[PCU_CFG_ACT +: PCU_ACTW];
    end
    // Capture engine
    if (cap_start) begin
      d.run = q.cfg;
      d.armed = 1'b0;
      d.touch = '0;
      d.cap_err = (start_fault != PCU_FLT_NONE);
      d.cap_st = (start_fault != PCU_FLT_NONE) ? PCU_CAP_IDLE : PCU_CAP_WAIT;
      if (start_fault != PCU_FLT_NONE) begin
        d.fault = start_fault;
      end
    end else if (q.cap_st == PCU_CAP_WAIT) begin
      if (hit) begin
        if (q.run.pol) begin
          d.rise_val = cap_pos; // [RULE10] [RULE21]
        end else begin
          d.fall_val = cap_pos; // [RULE10] [RULE21]
        end
        if (single) begin
          d.cap_st = PCU_CAP_DONE; // [RULE1] [RULE5] [RULE8]
        end
        if (q.run.mode == PCU_M_HSC_ARMED) begin
          d.armed = 1'b0; // [RULE3]
        end
        if (q.run.mode == PCU_M_HSC_ARMED || q.run.mode == PCU_M_ENC_CONT) begin
          d.touch = q.touch + PCU_TOUCH_STEP; // [RULE20]
        end
      end
      if (q.run.mode == PCU_M_HSC_ARMED && arm_hit) begin
        d.armed = 1'b1; // [RULE3]
      end
      if (is_prb(q.run.mode) && i_probe.valid) begin
        d.probe_val[{i_probe.second, i_probe.rising}] = i_probe.pos; // [RULE12] [RULE13]
      end
    end
    // Abort engine
    unique case (q.abt_st)
      PCU_ABT_IDLE: begin
        if (abt_start) begin
          d.abt_st = PCU_ABT_RUN; // [RULE16]
          d.abt_done = 1'b0;
          d.abt_aborted = 1'b0;
          d.abt_err = 1'b0;
        end
      end
      PCU_ABT_RUN: begin
        d.abt_st = PCU_ABT_IDLE;
        if (cap_start) begin
          d.abt_aborted = 1'b1; // [RULE17]
        end else if (q.abt_axis != q.run.axis) begin
          d.abt_err = 1'b1; // [RULE17]
          d.fault = PCU_FLT_ABT_AXIS;
        end else if (q.cap_st != PCU_CAP_WAIT) begin
          d.abt_err = 1'b1; // [RULE17]
          d.fault = PCU_FLT_ABT_IDLE;
        end else begin
          d.cap_st = PCU_CAP_IDLE;
          d.abt_done = 1'b1; // [RULE17]
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_rising_latch_value = q.rise_val;
  assign o_falling_latch_value = q.fall_val;
  assign o_capture_busy = (q.cap_st == PCU_CAP_WAIT);
  assign o_capture_done = (q.cap_st == PCU_CAP_DONE);
  assign o_latch_count = q.touch;
  assign o_abort_busy = (q.abt_st == PCU_ABT_RUN); // [RULE17]

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  property p_single_hold;
    (q.cap_st == PCU_CAP_DONE && q.run.mode == PCU_M_HSC_SINGLE && !cap_start)
      |=> $stable(q.rise_val) && $stable(q.fall_val);
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single capture value changed"); // [RULE1]

  property p_cont_update;
    (q.cap_st == PCU_CAP_WAIT && q.run.mode == PCU_M_HSC_CONT && trig_hit && !cap_start && !o_abort_busy)
      |=> ((q.run.pol ? o_rising_latch_value : o_falling_latch_value) == $past(hsc_pos)) && o_capture_busy;
  endproperty
  a_cont_update: assert property (p_cont_update) else $error("continuous capture missed"); // [RULE2]

  property p_armed_block;
    (q.cap_st == PCU_CAP_WAIT && q.run.mode == PCU_M_HSC_ARMED && !q.armed && !cap_start)
      |=> $stable(q.rise_val) && $stable(q.fall_val) && $stable(q.touch);
  endproperty
  a_armed_block: assert property (p_armed_block) else $error("unarmed capture taken"); // [RULE3]

  property p_enc_single;
    (q.cap_st == PCU_CAP_WAIT && q.run.mode == PCU_M_ENC_SINGLE && trig_hit && !cap_start && !o_abort_busy)
      |=> o_capture_done ##1 (o_capture_done || $past(cap_start));
  endproperty
  a_enc_single: assert property (p_enc_single) else $error("encoder single did not finish"); // [RULE5]

  property p_enc_cont;
    (q.cap_st == PCU_CAP_WAIT && q.run.mode == PCU_M_ENC_CONT && trig_hit && !cap_start)
      |=> ((q.run.pol ? o_rising_latch_value : o_falling_latch_value) == $past(enc_pos))
        && (o_latch_count == $past(q.touch) + 2'h1);
  endproperty
  a_enc_cont: assert property (p_enc_cont) else $error("encoder continuous capture wrong"); // [RULE6] [RULE20]

  property p_probe_single;
    (q.cap_st == PCU_CAP_WAIT && q.run.mode == PCU_M_PRB_SINGLE && prb_hit && !cap_start && !o_abort_busy)
      |=> o_capture_done && ((q.run.pol ? q.rise_val : q.fall_val) == $past(i_probe.pos));
  endproperty
  a_probe_single: assert property (p_probe_single) else $error("probe capture wrong"); // [RULE8]

  property p_probe_slot;
    (q.cap_st == PCU_CAP_WAIT && is_prb(q.run.mode) && i_probe.valid && !cap_start)
      |=> q.probe_val[{$past(i_probe.second), $past(i_probe.rising)}] == $past(i_probe.pos);
  endproperty
  a_probe_slot: assert property (p_probe_slot) else $error("probe slot not stored"); // [RULE12]

  property p_abort_seq;
    abt_start |=> o_abort_busy ##1 (!o_abort_busy && (q.abt_done || q.abt_aborted || q.abt_err));
  endproperty
  a_abort_seq: assert property (p_abort_seq) else $error("abort sequence wrong"); // [RULE16] [RULE17]

  property p_abort_stops;
    (o_abort_busy && !cap_start && q.abt_axis == q.run.axis && o_capture_busy) |=> !o_capture_busy && q.abt_done;
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("abort did not stop capture"); // [RULE17]

  c_single_capture: cover property (o_capture_busy && q.run.mode == PCU_M_HSC_SINGLE ##1 o_capture_done);
  c_armed_capture: cover property (q.run.mode == PCU_M_HSC_ARMED && q.armed && hit);
  c_probe_two: cover property (o_capture_busy && prb_two && prb_hit);
  c_abort_done: cover property (o_abort_busy ##1 q.abt_done);
endmodule : pcu_capture

/* logic/pcu_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_ref_clk
// Notes: Level changes once stages two and three agree
module pcu_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Levels
  input wire logic [W-1:0] i_raw,
  output logic [W-1:0] o_level
);
  if (W < 1) begin : g_bad_w
    $error("pcu_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pcu_sync_s;

  pcu_sync_s q;
  pcu_sync_s d;

  always_comb begin
    d = q;
    d.s1 = i_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lvl;
endmodule : pcu_sync

/* test/pcu_far_model.sv */
// Purpose: Far side of the capture unit: counters, encoders, servo probes
// Assumes: Positions hold steady while the bench keeps the epoch
// Notes: Probe reply short or long; probe position is noise when idle
module pcu_far_model
  import pcu_pkg::*;
#(
  parameter int N_HSC = 5,
  parameter int N_ENC = 5
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Bench control
  input wire logic [7:0] i_epoch,
  input wire logic i_slow,
  input wire logic i_probe_req,
  input wire logic i_probe_second,
  input wire logic i_probe_rising,
  // Positions
  output logic [N_HSC*PCU_PW-1:0] o_hsc_pos,
  output logic [N_ENC*PCU_PW-1:0] o_enc_pos,
  output pcu_probe_s o_probe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic pend_q;
  logic fire_q;
  logic sec_q;
  logic rise_q;
  logic [PCU_PW-1:0] noise_q;
  // Channel values per channel and epoch
  always_comb begin
    for (int k = 0; k < N_HSC; k++) begin
      o_hsc_pos[k*PCU_PW +: PCU_PW] = {8'h10, 4'h0, 4'(k), i_epoch, 8'h5a};
    end
    for (int k = 0; k < N_ENC; k++) begin
      o_enc_pos[k*PCU_PW +: PCU_PW] = {8'h20, 5'h00, 3'(k), i_epoch, 8'h5a};
    end
  end
  // Probe report of first or second probe input
  assign o_probe.valid = fire_q;
  assign o_probe.second = sec_q;
  assign o_probe.rising = rise_q;
  assign o_probe.pos = fire_q ? {8'h30, 6'h00, sec_q, rise_q, i_epoch, 8'h5a} : noise_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pend_q <= 1'b0;
      fire_q <= 1'b0;
      wait_q <= 4'h0;
      noise_q <= 32'h0000_0000;
    end else begin
      noise_q <= ~noise_q + 32'h0001_0101;
      fire_q <= 1'b0;
      if (i_probe_req) begin
        pend_q <= 1'b1;
        wait_q <= i_slow ? 4'h6 : 4'h0;
        sec_q <= i_probe_second;
        rise_q <= i_probe_rising;
      end else if (pend_q && wait_q == 4'h0) begin
        pend_q <= 1'b0;
        fire_q <= 1'b1;
      end else if (pend_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : pcu_far_model

/* test/tb_position_capture_unit.sv */
// Purpose: Self-checking bench of the position capture unit
// Assumes: Far side model supplies counter, encoder and probe positions
// Notes: Table rows run every capture mode, hand tests follow
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_position_capture_unit
  import pcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] mode;
    logic pol;
    logic [3:0] sel;
    logic [7:0] axis;
    logic [2:0] src;
    logic cont;
    logic done;
    logic [1:0] dcnt;
  } pcu_row_s;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [PCU_AW-1:0] reg_addr = 8'h00;
  logic [PCU_DW-1:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [PCU_DW-1:0] reg_rdata;
  logic [PCU_NDI-1:0] dig_in = 16'h0000;
  logic [5*PCU_PW-1:0] hsc_pos;
  logic [5*PCU_PW-1:0] enc_pos;
  pcu_probe_s probe;
  logic [PCU_PW-1:0] rise_val;
  logic [PCU_PW-1:0] fall_val;
  logic cap_busy;
  logic cap_done;
  logic [1:0] latch_cnt;
  logic abt_busy;
  logic [7:0] epoch = 8'h00;
  logic slow = 1'b0;
  logic prb_req = 1'b0;
  logic prb_sec = 1'b0;
  logic prb_rise = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  // Mode, polarity, trigger, axis, source, continuous, done, count step
  pcu_row_s rows [7] = '{
    '{3'h0, 1'b1, 4'h0, 8'h02, 3'h4, 1'b0, 1'b1, 2'h0},
    '{3'h1, 1'b0, 4'h9, 8'h04, 3'h0, 1'b1, 1'b0, 2'h0},
    '{3'h2, 1'b1, 4'hf, 8'h01, 3'h3, 1'b0, 1'b0, 2'h1},
    '{3'h3, 1'b0, 4'h3, 8'h07, 3'h1, 1'b0, 1'b1, 2'h0},
    '{3'h4, 1'b1, 4'hc, 8'h09, 3'h2, 1'b1, 1'b0, 2'h2},
    '{3'h5, 1'b0, 4'h7, 8'h03, 3'h4, 1'b0, 1'b1, 2'h0},
    '{3'h6, 1'b1, 4'h8, 8'h22, 3'h0, 1'b1, 1'b0, 2'h0}
  };
  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  pcu_capture #(.N_HSC(5), .N_ENC(5)) i_dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_dig_in(dig_in),
    .i_hsc_pos(hsc_pos), .i_enc_pos(enc_pos), .i_probe(probe), .o_rising_latch_value(rise_val),
    .o_falling_latch_value(fall_val), .o_capture_busy(cap_busy), .o_capture_done(cap_done),
    .o_latch_count(latch_cnt), .o_abort_busy(abt_busy)
  );
  pcu_far_model #(.N_HSC(5), .N_ENC(5)) i_far (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_epoch(epoch), .i_slow(slow), .i_probe_req(prb_req),
    .i_probe_second(prb_sec), .i_probe_rising(prb_rise), .o_hsc_pos(hsc_pos), .o_enc_pos(enc_pos),
    .o_probe(probe)
  );
  function automatic logic [31:0] exp_pos(pcu_row_s r, logic [7:0] ep);
    if (r.mode < 3'h3) return {8'h10, 4'h0, r.axis[3:0], ep, 8'h5a};
    if (r.mode < 3'h5) return {8'h20, 5'h00, r.src, ep, 8'h5a};
    return {8'h30, 6'h00, r.axis >= 8'h20, r.pol, ep, 8'h5a};
  endfunction : exp_pos
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read
  task automatic start(input logic [31:0] cfg);
    reg_write(PCU_REG_CFG, cfg);
    reg_write(PCU_REG_CTRL, 32'h0000_0000);
    reg_write(PCU_REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge i_ref_clk);
  endtask : start
  task automatic edge_on(input int idx, input logic lvl);
    @(posedge i_ref_clk);
    dig_in[idx] <= ~lvl;
    repeat (6) @(posedge i_ref_clk);
    dig_in[idx] <= lvl;
    repeat (8) @(posedge i_ref_clk);
    dig_in[idx] <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask : edge_on
  task automatic fire(input pcu_row_s r);
    if (r.mode < 3'h5) begin
      edge_on(int'(r.sel), r.pol);
    end else begin
      @(posedge i_ref_clk);
      prb_req <= 1'b1;
      prb_sec <= r.axis >= 8'h20;
      prb_rise <= r.pol;
      @(posedge i_ref_clk);
      prb_req <= 1'b0;
      repeat (14) @(posedge i_ref_clk);
    end
  endtask : fire
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200us;
    num_errors++;
    report_and_stop();
  end
  initial begin
    pcu_row_s r;
    logic [31:0] v0;
    logic [31:0] d;
    logic [1:0] c0;
    int n;
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    `CHK({rise_val, fall_val, cap_busy, cap_done, latch_cnt, abt_busy}, 69'h0)
    reg_read(PCU_REG_CFG, d);
    `CHK(d, 32'h0000_0000)
    foreach (rows[i]) begin
      r = rows[i];
      slow <= (i == 6);
      epoch <= 8'h40 + 8'(i);
      start({5'h00, r.src, r.axis, 8'h05, r.sel, r.pol, r.mode});
      `CHK(cap_busy, 1'b1)
      c0 = latch_cnt;
      if (r.mode == 3'h2) edge_on(5, 1'b1);
      fire(r);
      v0 = exp_pos(r, epoch);
      `CHK(r.pol ? rise_val : fall_val, v0)
      `CHK(cap_done, r.done)
      epoch <= epoch + 8'h01;
      fire(r);
      `CHK(r.pol ? rise_val : fall_val, r.cont ? exp_pos(r, epoch) : v0)
      `CHK(2'(latch_cnt - c0), r.dcnt)
      if (r.mode > 3'h4) begin
        reg_read(8'h18 + {4'h0, r.axis >= 8'h20, r.pol, 2'h0}, d);
        `CHK(d, r.cont ? exp_pos(r, epoch) : v0)
      end
      if (!r.done) begin
        reg_write(PCU_REG_CTRL, {16'h0000, r.axis, 8'h02});
        n = 0;
        repeat (6) begin
          @(posedge i_ref_clk);
          if (abt_busy === 1'b1) n++;
        end
        `CHK(n, 1)
        `CHK(cap_busy, 1'b0)
        reg_read(PCU_REG_STAT, d);
        `CHK(d[PCU_ST_ABT_DONE], 1'b1)
      end
    end
    // Abort naming a foreign axis, then the right one
    start({16'h0002, 8'h05, 4'h1, 1'b1, 3'h1});
    reg_write(PCU_REG_CTRL, 32'h0000_0302);
    repeat (3) @(posedge i_ref_clk);
    reg_read(PCU_REG_FAULT, d);
    `CHK(d[15:0], PCU_FLT_ABT_AXIS)
    `CHK(cap_busy, 1'b1)
    reg_write(PCU_REG_CTRL, 32'h0000_0000);
    reg_write(PCU_REG_CTRL, 32'h0000_0202);
    repeat (3) @(posedge i_ref_clk);
    `CHK(cap_busy, 1'b0)
    // Abort with no capture waiting
    reg_write(PCU_REG_CTRL, 32'h0000_0000);
    reg_write(PCU_REG_CTRL, 32'h0000_0202);
    repeat (3) @(posedge i_ref_clk);
    reg_read(PCU_REG_FAULT, d);
    `CHK(d[15:0], PCU_FLT_ABT_IDLE)
    reg_read(PCU_REG_STAT, d);
    `CHK(d[PCU_ST_ABT_ERR], 1'b1)
    reg_read(8'h3c, d);
    `CHK(d, 32'h0000_0000)
    // Restart in the abort busy cycle reports aborted
    reg_write(PCU_REG_CTRL, 32'h0000_0000);
    @(posedge i_ref_clk);
    reg_addr <= PCU_REG_CTRL;
    reg_wdata <= 32'h0000_0202;
    reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    reg_wdata <= 32'h0000_0203;
    @(posedge i_ref_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    reg_read(PCU_REG_STAT, d);
    `CHK({d[PCU_ST_ABORTED], d[PCU_ST_CAP_BUSY]}, 2'h3)
    // Refused configurations
    start(32'h0007_0000);
    reg_read(PCU_REG_FAULT, d);
    `CHK({cap_busy, d[15:0]}, {1'b0, PCU_FLT_AXIS})
    start(32'h0000_0007);
    reg_read(PCU_REG_FAULT, d);
    `CHK({cap_busy, d[15:0]}, {1'b0, PCU_FLT_MODE})
    // Reset in mid-run
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    `CHK({rise_val, fall_val, cap_busy, cap_done, latch_cnt, abt_busy}, 69'h0)
    reg_read(PCU_REG_FAULT, d);
    `CHK(d, 32'h0000_0000)
    report_and_stop();
  end
endmodule : tb_position_capture_unit
